// ---- msw_pkg.sv ----
// Constants and types shared by the machine state word unit.
// Assumes the core numbers state bits from 0 at the most significant end.
package msw_pkg;

    // ****************************************************************
    // Bit positions, converted from core numbering to vector indexes.
    // ****************************************************************
    localparam int MSB_NUM          = 31;
    localparam int POS_POW          = MSB_NUM - 13;
    localparam int POS_SHADOW_GP_REMAP         = MSB_NUM - 14;
    localparam int POS_ILE          = MSB_NUM - 15;
    localparam int POS_EE           = MSB_NUM - 16;
    localparam int POS_PR           = MSB_NUM - 17;
    localparam int POS_LE           = MSB_NUM - 31;

    // ****************************************************************
    // Save masks and reset values.
    // ****************************************************************
    localparam logic [31:0] FULL_RSV_MASK  = 32'h87C0_0000;
    localparam logic [31:0] UPPER_HALF_MASK = 32'h0000_FFFF;
    localparam logic [31:0] INFO_MASK      = 32'hFFFF_0000;
    localparam logic [31:0] MSW_RESET      = 32'h0000_0000;
    localparam logic [31:0] SAVED_RESET    = 32'h0000_0000;

    // ****************************************************************
    // Register file layout and synchroniser depth.
    // ****************************************************************
    localparam int          GPR_COUNT      = 32;
    localparam int          SHADOW_COUNT   = 4;
    localparam logic [4:0]  SHADOW_LIMIT   = 5'h04;
    localparam int          SYNC_STAGES    = 3;

    // ****************************************************************
    // Exception kinds and low power modes.
    // ****************************************************************
    typedef enum logic [1:0] {
        EXC_OTHER    = 2'h0,
        EXC_ITLB     = 2'h1,
        EXC_DTLB_LD  = 2'h3,
        EXC_DTLB_ST  = 2'h2
    } exc_kind_t;

    typedef enum logic [1:0] {
        PM_RUN   = 2'h0,
        PM_NAP   = 2'h1,
        PM_DOZE  = 2'h3,
        PM_SLEEP = 2'h2
    } power_mode_t;

endpackage

// ---- gpr_if.sv ----
// Interface between the state word unit and the general register bank.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface gpr_if;
    logic        remap;
    logic [4:0]  rdAddrA;
    logic [4:0]  rdAddrB;
    logic [31:0] rdDataA;
    logic [31:0] rdDataB;
    logic        wrEn;
    logic [4:0]  wrAddr;
    logic [31:0] wrData;

    modport ctrl (
        output remap, rdAddrA, rdAddrB, wrEn, wrAddr, wrData,
        input  rdDataA, rdDataB
    );
    modport bank (
        input  remap, rdAddrA, rdAddrB, wrEn, wrAddr, wrData,
        output rdDataA, rdDataB
    );
endinterface

// ---- pin_sync.sv ----
// Three stage synchroniser with agreement filter for asynchronous pins.
// Assumes inputs may change at any time relative to clk_sys.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset.
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Pins and filtered levels.
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] levelOut
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] level_ff;
    logic [WIDTH-1:0] nxt_level;

    // A level is accepted only once stages two and three agree.
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            nxt_level[i] = (stage2_ff[i] == stage3_ff[i]) ? stage3_ff[i]
                                                          : level_ff[i];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
            level_ff  <= '0;
        end else begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            level_ff  <= nxt_level;
        end
    end

    assign levelOut = level_ff;
endmodule

// ---- gpr_bank.sv ----
// General register bank with four shadow registers for miss handlers.
// Assumes the controller registers the read data it returns.
`timescale 1ns/1ps
module gpr_bank (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Access port.
    gpr_if.bank      port
);
    logic [31:0] gpr_ff    [msw_pkg::GPR_COUNT];
    logic [31:0] shadow_ff [msw_pkg::SHADOW_COUNT];
    logic        lowA;
    logic        lowB;
    logic        lowW;

    assign lowA = port.remap && (port.rdAddrA < msw_pkg::SHADOW_LIMIT);
    assign lowB = port.remap && (port.rdAddrB < msw_pkg::SHADOW_LIMIT);
    assign lowW = port.remap && (port.wrAddr < msw_pkg::SHADOW_LIMIT);

    // Low addresses steer to the shadow set while remapping.
    assign port.rdDataA = lowA ? shadow_ff[port.rdAddrA[1:0]]
                               : gpr_ff[port.rdAddrA];
    assign port.rdDataB = lowB ? shadow_ff[port.rdAddrB[1:0]]
                               : gpr_ff[port.rdAddrB];

    // ****************************************************************
    // Storage, one entry per generate step.
    // ****************************************************************
    for (genvar g = 0; g < msw_pkg::GPR_COUNT; g++) begin : g_gpr
        logic [31:0] nxt_gpr;
        // Originals stay frozen while the shadow set is in use.
        always_comb begin
            nxt_gpr = gpr_ff[g];
            if (port.wrEn && !lowW && (port.wrAddr == 5'(g))) begin
                nxt_gpr = port.wrData;
            end
        end
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                gpr_ff[g] <= 32'h0000_0000;
            end else begin
                gpr_ff[g] <= nxt_gpr;
            end
        end
    end

    for (genvar s = 0; s < msw_pkg::SHADOW_COUNT; s++) begin : g_shadow
        logic [31:0] nxt_shadow;
        always_comb begin
            nxt_shadow = shadow_ff[s];
            if (port.wrEn && lowW && (port.wrAddr[1:0] == 2'(s))) begin
                nxt_shadow = port.wrData;
            end
        end
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                shadow_ff[s] <= 32'h0000_0000;
            end else begin
                shadow_ff[s] <= nxt_shadow;
            end
        end
    end
endmodule

// ---- machine_state_unit.sv ----
// Machine state word, saved status and the logic steered by state bits.
// Assumes the pipeline presents one exception, return or move per cycle.
`timescale 1ns/1ps
module machine_state_unit (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // State word moves.
    input  wire logic        msrWrite,
    input  wire logic [31:0] msrWrData,
    input  wire logic        savedWrite,
    input  wire logic [31:0] savedWrData,
    // Exception entry and return.
    input  wire logic        excTake,
    input  wire logic [1:0]  excKind,
    input  wire logic [31:0] excInfo,
    input  wire logic        rfiExec,
    // Asynchronous interrupt pins: external, management, decrementer.
    input  wire logic [2:0]  irqPins,
    // Power control.
    input  wire logic [1:0]  powerModeReq,
    input  wire logic        dpmIdle,
    // Instruction privilege check.
    input  wire logic        instrValid,
    input  wire logic        instrSupervisor,
    // Register file access.
    input  wire logic [4:0]  gprRdAddrA,
    input  wire logic [4:0]  gprRdAddrB,
    input  wire logic        gprWrEn,
    input  wire logic [4:0]  gprWrAddr,
    input  wire logic [31:0] gprWrData,
    // State outputs.
    output logic      [31:0] machineState,
    output logic      [31:0] savedStatus,
    output logic      [31:0] gprRdDataA,
    output logic      [31:0] gprRdDataB,
    output logic             asyncIntReq,
    output logic      [1:0]  powerMode,
    output logic             dpmGate,
    output logic             privFault,
    output logic             littleEndian
);
    // ****************************************************************
    // Storage.
    // ****************************************************************
    logic [31:0] msw_ff;
    logic [31:0] nxt_msw;
    logic [31:0] saved_ff;
    logic [31:0] nxt_saved;
    logic [31:0] rdA_ff;
    logic [31:0] rdB_ff;
    logic        intReq_ff;
    logic        nxt_intReq;
    logic [1:0]  pmode_ff;
    logic [1:0]  nxt_pmode;
    logic        dpm_ff;
    logic        priv_ff;
    logic        nxt_priv;
    logic        le_ff;
    logic [2:0]  irqLevel;
    logic        tlbMiss;

    gpr_if gprPort ();

    pin_sync #(.WIDTH(3)) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .pinIn    (irqPins),
        .levelOut (irqLevel)
    );

    gpr_bank u_bank (
        .clk_sys (clk_sys),
        .rst     (rst),
        .port    (gprPort.bank)
    );

    // ****************************************************************
    // State word and saved status.
    // ****************************************************************
    assign tlbMiss = (excKind == msw_pkg::EXC_ITLB)
                  || (excKind == msw_pkg::EXC_DTLB_LD)
                  || (excKind == msw_pkg::EXC_DTLB_ST);

    // Exception entry wins over a return or a move in the same cycle,
    // since the pipeline flushes the younger instruction anyway.
    always_comb begin
        nxt_msw   = msw_ff;
        nxt_saved = saved_ff;
        if (excTake) begin
            nxt_saved = (excInfo & msw_pkg::INFO_MASK
                         & ~msw_pkg::FULL_RSV_MASK)
                      | (msw_ff & msw_pkg::FULL_RSV_MASK)
                      | (msw_ff & msw_pkg::UPPER_HALF_MASK);
            nxt_msw[msw_pkg::POS_EE] = 1'b0;
            nxt_msw[msw_pkg::POS_PR] = 1'b0;
            nxt_msw[msw_pkg::POS_POW] = 1'b0;
            nxt_msw[msw_pkg::POS_LE] = msw_ff[msw_pkg::POS_ILE];
            if (tlbMiss) begin
                nxt_msw[msw_pkg::POS_SHADOW_GP_REMAP] = 1'b1;
            end
        end else if (rfiExec) begin
            nxt_msw = saved_ff;
            nxt_msw[msw_pkg::POS_SHADOW_GP_REMAP] = 1'b0;
        end else begin
            if (msrWrite) begin
                nxt_msw = msrWrData;
            end
            if (savedWrite) begin
                nxt_saved = savedWrData;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            msw_ff   <= msw_pkg::MSW_RESET;
            saved_ff <= msw_pkg::SAVED_RESET;
        end else begin
            msw_ff   <= nxt_msw;
            saved_ff <= nxt_saved;
        end
    end

    // ****************************************************************
    // Steered logic: interrupts, power, privilege, byte order.
    // ****************************************************************
    // The gate is read from the current word, so a level that arrives
    // while an exception clears it is held off until software reopens it.
    always_comb begin
        nxt_intReq = msw_ff[msw_pkg::POS_EE] && !excTake
                  && (|irqLevel);
        nxt_pmode  = msw_pkg::PM_RUN;
        if (msw_ff[msw_pkg::POS_POW]) begin
            nxt_pmode = powerModeReq;
        end
        nxt_priv = instrValid && instrSupervisor
                && msw_ff[msw_pkg::POS_PR];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            intReq_ff <= 1'b0;
            pmode_ff  <= msw_pkg::PM_RUN;
            dpm_ff    <= 1'b0;
            priv_ff   <= 1'b0;
            le_ff     <= 1'b0;
        end else begin
            intReq_ff <= nxt_intReq;
            pmode_ff  <= nxt_pmode;
            dpm_ff    <= dpmIdle;
            priv_ff   <= nxt_priv;
            le_ff     <= nxt_msw[msw_pkg::POS_LE];
        end
    end

    // ****************************************************************
    // Register file port with shadow steering.
    // ****************************************************************
    // Accesses above the shadow range during remap are passed through;
    // their results are left to software discipline.
    assign gprPort.remap   = msw_ff[msw_pkg::POS_SHADOW_GP_REMAP];
    assign gprPort.rdAddrA = gprRdAddrA;
    assign gprPort.rdAddrB = gprRdAddrB;
    assign gprPort.wrEn    = gprWrEn;
    assign gprPort.wrAddr  = gprWrAddr;
    assign gprPort.wrData  = gprWrData;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdA_ff <= 32'h0000_0000;
            rdB_ff <= 32'h0000_0000;
        end else begin
            rdA_ff <= gprPort.rdDataA;
            rdB_ff <= gprPort.rdDataB;
        end
    end

    assign machineState = msw_ff;
    assign savedStatus  = saved_ff;
    assign gprRdDataA   = rdA_ff;
    assign gprRdDataB   = rdB_ff;
    assign asyncIntReq  = intReq_ff;
    assign powerMode    = pmode_ff;
    assign dpmGate      = dpm_ff;
    assign privFault    = priv_ff;
    assign littleEndian = le_ff;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    full_rsv_save_a: assert property (
        excTake |=> ((saved_ff & msw_pkg::FULL_RSV_MASK)
                     == ($past(msw_ff) & msw_pkg::FULL_RSV_MASK)))
        else $error("Full-function reserved bits not saved.");

    pow_off_run_a: assert property (
        !msw_ff[msw_pkg::POS_POW] |=> (pmode_ff == msw_pkg::PM_RUN))
        else $error("Low power mode entered while disabled.");

    pow_on_mode_a: assert property (
        msw_ff[msw_pkg::POS_POW] |=> (pmode_ff == $past(powerModeReq)))
        else $error("Requested power mode not passed when enabled.");

    dpm_indep_a: assert property (
        ##1 (dpm_ff == $past(dpmIdle)))
        else $error("Dynamic power gate depends on power enable.");

    shadow_gp_remap_set_a: assert property (
        (excTake && tlbMiss) |=> msw_ff[msw_pkg::POS_SHADOW_GP_REMAP])
        else $error("Shadow remap not set on a miss exception.");

    shadow_gp_remap_clear_a: assert property (
        (rfiExec && !excTake) |=> !msw_ff[msw_pkg::POS_SHADOW_GP_REMAP])
        else $error("Shadow remap survives exception return.");

    endian_copy_a: assert property (
        excTake |=> (msw_ff[msw_pkg::POS_LE]
                     == $past(msw_ff[msw_pkg::POS_ILE])) ##1
                    (le_ff == $past(msw_ff[msw_pkg::POS_LE])))
        else $error("Endian select not copied on exception.");

    gate_block_a: assert property (
        !msw_ff[msw_pkg::POS_EE] |=> !intReq_ff)
        else $error("Interrupt raised while gate is clear.");

    gate_pass_a: assert property (
        (msw_ff[msw_pkg::POS_EE] && !excTake && (|irqLevel)) |=> intReq_ff)
        else $error("Interrupt lost while gate is set.");

    priv_fault_a: assert property (
        (instrValid && instrSupervisor) |=>
            (priv_ff == $past(msw_ff[msw_pkg::POS_PR])))
        else $error("Privilege check wrong.");

    upper_save_a: assert property (
        excTake |=> ((saved_ff & msw_pkg::UPPER_HALF_MASK)
                     == ($past(msw_ff) & msw_pkg::UPPER_HALF_MASK)))
        else $error("State bits 16 to 31 not saved.");

    gate_clear_a: assert property (
        excTake |=> (!msw_ff[msw_pkg::POS_EE] && !intReq_ff))
        else $error("Interrupt gate not cleared on exception.");

    shadow_steer_a: assert property (
        (msw_ff[msw_pkg::POS_SHADOW_GP_REMAP] && (gprRdAddrA < msw_pkg::SHADOW_LIMIT)
         && gprWrEn && !excTake && !rfiExec && !msrWrite
         && (gprWrAddr == gprRdAddrA))
        |=> (u_bank.shadow_ff[$past(gprWrAddr[1:0])] == $past(gprWrData)))
        else $error("Shadow register not written during remap.");

    miss_entry_c: cover property (
        excTake && tlbMiss ##[1:20] rfiExec);
    int_taken_c: cover property (
        intReq_ff ##1 excTake);
    nap_entry_c: cover property (
        msrWrite && msrWrData[msw_pkg::POS_POW] ##2
        (pmode_ff != msw_pkg::PM_RUN));
    priv_trap_c: cover property (privFault);
endmodule

// ---- testbench.sv ----
// Self-checking bench for the machine state word unit.
// Assumes the unit's assertions sit in its own files; no checker here.
`timescale 1ns/1ps
module testbench;

    // ****************************************************************
    // Signals.
    // ****************************************************************
    logic        clk_sys;
    logic        rst;
    logic        msrWrite;
    logic [31:0] msrWrData;
    logic        savedWrite;
    logic [31:0] savedWrData;
    logic        excTake;
    logic [1:0]  excKind;
    logic [31:0] excInfo;
    logic        rfiExec;
    logic [2:0]  irqPins;
    logic [1:0]  powerModeReq;
    logic        dpmIdle;
    logic        instrValid;
    logic        instrSupervisor;
    logic [4:0]  gprRdAddrA;
    logic [4:0]  gprRdAddrB;
    logic        gprWrEn;
    logic [4:0]  gprWrAddr;
    logic [31:0] gprWrData;
    logic [31:0] machineState;
    logic [31:0] savedStatus;
    logic [31:0] gprRdDataA;
    logic [31:0] gprRdDataB;
    logic        asyncIntReq;
    logic [1:0]  powerMode;
    logic        dpmGate;
    logic        privFault;
    logic        littleEndian;
    int          nFail;
    int          checksDone;

    machine_state_unit DUT (
        .clk_sys(clk_sys), .rst(rst),
        .msrWrite(msrWrite), .msrWrData(msrWrData),
        .savedWrite(savedWrite), .savedWrData(savedWrData),
        .excTake(excTake), .excKind(excKind), .excInfo(excInfo),
        .rfiExec(rfiExec), .irqPins(irqPins),
        .powerModeReq(powerModeReq), .dpmIdle(dpmIdle),
        .instrValid(instrValid), .instrSupervisor(instrSupervisor),
        .gprRdAddrA(gprRdAddrA), .gprRdAddrB(gprRdAddrB),
        .gprWrEn(gprWrEn), .gprWrAddr(gprWrAddr), .gprWrData(gprWrData),
        .machineState(machineState), .savedStatus(savedStatus),
        .gprRdDataA(gprRdDataA), .gprRdDataB(gprRdDataB),
        .asyncIntReq(asyncIntReq), .powerMode(powerMode),
        .dpmGate(dpmGate), .privFault(privFault),
        .littleEndian(littleEndian)
    );

    always #12.5 clk_sys = ~clk_sys;

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    // Inputs move 1 ns after the edge so the sampling edge never races.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic mwr(input logic [31:0] d);
        msrWrite = 1'b1;
        msrWrData = d;
        cyc(1);
        msrWrite = 1'b0;
        cyc(1);
    endtask

    task automatic gwr(input logic [4:0] a, input logic [31:0] d);
        gprWrEn = 1'b1;
        gprWrAddr = a;
        gprWrData = d;
        cyc(1);
        gprWrEn = 1'b0;
        cyc(1);
    endtask

    task automatic grd(input logic [4:0] a, input logic [31:0] e);
        gprRdAddrA = a;
        gprRdAddrB = a;
        cyc(1);
        chk(gprRdDataA, e);
        chk(gprRdDataB, e);
    endtask

    // Saved status keeps full-function reserved bits and the low half.
    function automatic logic [31:0] expSaved(logic [31:0] m,
                                             logic [31:0] info);
        return (info & 32'h783F_0000) | (m & 32'h87C0_FFFF);
    endfunction

    function automatic logic [31:0] expMsw(logic [31:0] m, int k);
        logic [31:0] r;
        r = m;
        r[msw_pkg::POS_POW] = 1'b0;
        r[msw_pkg::POS_EE] = 1'b0;
        r[msw_pkg::POS_PR] = 1'b0;
        r[msw_pkg::POS_LE] = m[msw_pkg::POS_ILE];
        if (k != 0) begin
            r[msw_pkg::POS_SHADOW_GP_REMAP] = 1'b1;
        end
        return r;
    endfunction

    task automatic testDone;
        $display("checks %0d, mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************************************
    // Tests.
    // ****************************************************************
    initial begin
        #(25 * 5000);
        nFail++;
        testDone();
    end

    initial begin
        logic [31:0] m;
        logic [31:0] info;
        logic [31:0] e;
        logic [31:0] a [4];
        clk_sys = 1'b0; rst = 1'b1; nFail = 0; checksDone = 0;
        msrWrite = 1'b0; msrWrData = '0; savedWrite = 1'b0;
        savedWrData = '0; excTake = 1'b0; excKind = '0; excInfo = '0;
        rfiExec = 1'b0; irqPins = '0; powerModeReq = '0; dpmIdle = 1'b0;
        instrValid = 1'b0; instrSupervisor = 1'b0; gprRdAddrA = '0;
        gprRdAddrB = '0; gprWrEn = 1'b0; gprWrAddr = '0; gprWrData = '0;
        void'($urandom(18));
        cyc(8);
        rst = 1'b0;
        // Every exception kind; kind 2 also races a refused state write.
        for (int k = 0; k < 4; k++) begin
            m = $urandom;
            m[msw_pkg::POS_EE] = 1'b1;
            mwr(m);
            info = $urandom;
            excTake = 1'b1;
            excKind = 2'(k);
            excInfo = info;
            if (k == 2) begin
                msrWrite = 1'b1;
                msrWrData = ~m;
            end
            cyc(1);
            excTake = 1'b0;
            msrWrite = 1'b0;
            chk(savedStatus, expSaved(m, info));
            chk(machineState, expMsw(m, k));
            cyc(1);
            chk(32'(littleEndian), 32'(m[0 + msw_pkg::POS_ILE]));
            rfiExec = 1'b1;
            cyc(1);
            rfiExec = 1'b0;
            e = expSaved(m, info);
            e[msw_pkg::POS_SHADOW_GP_REMAP] = 1'b0;
            chk(machineState, e);
        end
        $display("exception test done");
        // Originals survive while the shadow set is in use.
        mwr(32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            a[i] = $urandom;
            gwr(5'(i), a[i]);
        end
        m = '0;
        m[msw_pkg::POS_SHADOW_GP_REMAP] = 1'b1;
        mwr(m);
        for (int i = 0; i < 4; i++) begin
            gwr(5'(i), ~a[i]);
        end
        for (int i = 0; i < 4; i++) begin
            grd(5'(i), ~a[i]);
        end
        mwr(32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            grd(5'(i), a[i]);
        end
        $display("shadow register test done");
        // Each interrupt pin alone, gate open then closed by an exception.
        for (int p = 0; p < 3; p++) begin
            m = '0;
            m[msw_pkg::POS_EE] = 1'b1;
            mwr(m);
            irqPins = 3'(1 << p);
            for (int i = 0; i < 12 && asyncIntReq !== 1'b1; i++) begin
                cyc(1);
            end
            chk(32'(asyncIntReq), 32'h1);
            excTake = 1'b1;
            excKind = 2'h0;
            cyc(1);
            excTake = 1'b0;
            chk(32'(asyncIntReq), 32'h0);
            cyc(8);
            chk(32'(asyncIntReq), 32'h0);
            irqPins = '0;
            cyc(8);
        end
        $display("interrupt test done");
        // Low power modes only with the enable set; idle gating always.
        for (int pw = 1; pw >= 0; pw--) begin
            m = '0;
            m[msw_pkg::POS_POW] = 1'(pw);
            mwr(m);
            for (int p = 0; p < 4; p++) begin
                powerModeReq = 2'(p);
                dpmIdle = 1'($urandom);
                cyc(1);
                chk(32'(powerMode), pw ? 32'(p) : 32'h0);
                chk(32'(dpmGate), 32'(dpmIdle));
            end
        end
        $display("power test done");
        for (int pr = 0; pr < 2; pr++) begin
            m = '0;
            m[msw_pkg::POS_PR] = 1'(pr);
            mwr(m);
            for (int s = 0; s < 2; s++) begin
                instrValid = 1'b1;
                instrSupervisor = 1'(s);
                cyc(1);
                chk(32'(privFault), 32'(pr & s));
            end
            instrValid = 1'b0;
        end
        $display("privilege test done");
        // A handler may rewrite the saved status before returning.
        e = $urandom;
        savedWrData = e;
        savedWrite = 1'b1;
        cyc(1);
        savedWrite = 1'b0;
        chk(savedStatus, e);
        rfiExec = 1'b1;
        cyc(1);
        rfiExec = 1'b0;
        e[msw_pkg::POS_SHADOW_GP_REMAP] = 1'b0;
        chk(machineState, e);
        $display("restore test done");
        testDone();
    end

endmodule
